/* design/core_port_map.svh */
// offsets, bit positions and reset values of the core port configuration block
`ifndef CORE_PORT_MAP_SVH
`define CORE_PORT_MAP_SVH

// ************************************
// register byte addresses
// ************************************
`define PULL_OFS    8'h00
`define DRIVE_OFS   8'h04
`define EBUS_OFS    8'h08
`define RSVD_OFS    8'h0c
`define EXTINT_OFS  8'h10
`define MODE_OFS    8'h14
`define STATUS_OFS  8'h18

// ************************************
// field positions
// ************************************
`define PORT_K_BIT  7
`define PORT_E_BIT  4
`define PORT_B_BIT  1
`define PORT_A_BIT  0
`define STRETCH_BIT 0
`define EDGE_BIT    7
`define CONNECT_BIT 6
`define MODE_LSB    5
`define MODE_MSB    7

// ************************************
// masks and reset values
// ************************************
`define PORT_MASK   8'h93
`define PORT_E_MASK 8'h9f
`define PULL_RST    8'h00
`define DRIVE_RST   8'h00
`define EXTINT_RST  8'h40
`define PORT_E_RST_PULL 8'h60

`endif

/* design/core_port_pkg.sv */
// types shared by the core port configuration block
package core_port_pkg;

  typedef enum logic [2:0] {
    MODE_SPC_SINGLE = 3'b000,
    MODE_EMU_NARROW = 3'b001,
    MODE_SPC_TEST   = 3'b010,
    MODE_EMU_WIDE   = 3'b011,
    MODE_NRM_SINGLE = 3'b100,
    MODE_NRM_NARROW = 3'b101,
    MODE_SPC_PERIPH = 3'b110,
    MODE_NRM_WIDE   = 3'b111
  } opmode_t;

  typedef logic [7:0] byte_t;

endpackage

/* design/irq_edge_if.sv */
// link between the register bank and the external interrupt detector
interface irq_edge_if;
  logic edge_sel;
  logic connect;
  logic service;
  logic req;
  logic latched;
  logic level;

  modport det (
    input  edge_sel,
    input  connect,
    input  service,
    output req,
    output latched,
    output level
  );

  modport ctl (
    output edge_sel,
    output connect,
    output service,
    input  req,
    input  latched,
    input  level
  );
endinterface

/* design/ext_int_detect.sv */
// external interrupt pin synchroniser, falling edge latch and request
module ext_int_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic irq_pin_n,
  irq_edge_if.det   ei
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic latch_q;
  logic fall;

  // ************************************
  // three stage pin sampling
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else if (clk_en) begin
      s1_q <= irq_pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b1;
    end else if (clk_en && (s2_q == s3_q)) begin
      level_q <= s3_q;
    end
  end

  assign fall = level_q && !s2_q && !s3_q;

  // ************************************
  // edge latch
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
    end else if (clk_en) begin
      if (!ei.connect) begin
        latch_q <= 1'b0;
      end else if (ei.edge_sel && fall) begin
        latch_q <= 1'b1;
      end else if (ei.service) begin
        latch_q <= 1'b0;
      end
    end
  end

  // low level when level mode, latched edge otherwise
  assign ei.req     = ei.connect && (ei.edge_sel ? latch_q : !level_q);
  assign ei.latched = latch_q;
  assign ei.level   = level_q;

endmodule

/* design/core_port_config_regs.sv */
// core port pull, drive, bus control, interrupt control and mode registers
// Summary of operation
// - port pull enable covers all its inputs
// - output pins never get pull resistors; here a pull drops at the next enabled edge after a pin turns output
// - bit 7 pulls port K inputs
// - bit 4 pulls port E pins 7,4:0
// - port E pins 5,6 pull only in reset
// - bits 1,0 pull ports B, A
// - drive bits 7,4,1,0 reduce port drive
// - reduced drive independent of pin function
// - pull, drive registers read/write while mapped
// - expanded, peripheral modes forward to external bus
// - stretch bit 0 selects E clock behaviour
// - stretch bit write once, special anytime
// - reserved slot reads zero, ignores writes
// - bit 7 selects low level or falling edge
// - edge latch held until reset or service
// - edge select write once, special anytime
// - bit 6 connects pin, always writable
// - disconnected pin holds edge latch clear
// - secure state blocks mode bit writes
// - special to normal single leaves one write
// - mode bits 7:5 give operating mode
//
// Added by the designer: the register offsets and the APB register port.
`include "core_port_map.svh"

module core_port_config_regs
  import core_port_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  mode_strap,
  input  wire logic        secure_mode,
  input  wire logic [7:0]  dir_port_a,
  input  wire logic [7:0]  dir_port_b,
  input  wire logic [7:0]  dir_port_e,
  input  wire logic [7:0]  dir_port_k,
  input  wire logic        irq_pin_n,
  input  wire logic        irq_service,
  output logic      [7:0]  pull_port_a,
  output logic      [7:0]  pull_port_b,
  output logic      [7:0]  pull_port_e,
  output logic      [7:0]  pull_port_k,
  output logic      [7:0]  low_drive_a,
  output logic      [7:0]  low_drive_b,
  output logic      [7:0]  low_drive_e,
  output logic      [7:0]  low_drive_k,
  output logic             eclk_stretch_en,
  output logic             ext_echo,
  output logic             ext_int_req,
  output logic      [2:0]  opmode
);

  // ************************************
  // helper functions
  // ************************************
  function automatic logic map_present(input opmode_t m);
    map_present = !m[0] && (m != MODE_SPC_PERIPH);
  endfunction

  function automatic logic is_special(input opmode_t m);
    is_special = (m == MODE_SPC_SINGLE) || (m == MODE_SPC_TEST)
              || (m == MODE_SPC_PERIPH);
  endfunction

  // an enable only reaches pins that are inputs
  function automatic byte_t pull_mask(input logic en, input byte_t dir);
    pull_mask = en ? ~dir : 8'h00;
  endfunction

  // ************************************
  // state
  // ************************************
  opmode_t     mode_q;
  logic        strap_done_q;
  logic        mode_once_used_q;
  byte_t       pull_q;
  byte_t       drive_q;
  logic        stretch_q;
  logic        stretch_used_q;
  logic        edge_sel_q;
  logic        edge_used_q;
  logic        connect_q;
  logic        in_reset_q;
  logic        rd_valid_q;
  byte_t       rd_data_q;
  logic        rd_err_q;
  logic        echo_q;
  byte_t       pull_a_q;
  byte_t       pull_b_q;
  byte_t       pull_e_q;
  byte_t       pull_k_q;
  irq_edge_if  ei ();

  // ************************************
  // bus decode
  // ************************************
  logic        present;
  logic        setup;
  logic        wr_fire;
  logic        sel_pull;
  logic        sel_drive;
  logic        sel_ebus;
  logic        sel_rsvd;
  logic        sel_extint;
  logic        sel_mode;
  logic        sel_status;
  logic        sel_any;
  byte_t       wbyte;
  byte_t       rd_d;
  opmode_t     mode_new;
  logic        mode_ok;

  assign present = map_present(mode_q);
  assign setup   = clk_en && psel && !penable;
  assign wr_fire = clk_en && psel && penable && pready && pwrite && present;
  assign wbyte   = pwdata[7:0];
  assign mode_new = opmode_t'(wbyte[`MODE_MSB:`MODE_LSB]);

  always_comb begin
    sel_pull   = 1'b0;
    sel_drive  = 1'b0;
    sel_ebus   = 1'b0;
    sel_rsvd   = 1'b0;
    sel_extint = 1'b0;
    sel_mode   = 1'b0;
    sel_status = 1'b0;
    if (paddr == `PULL_OFS) begin
      sel_pull = 1'b1;
    end else if (paddr == `DRIVE_OFS) begin
      sel_drive = 1'b1;
    end else if (paddr == `EBUS_OFS) begin
      sel_ebus = 1'b1;
    end else if (paddr == `RSVD_OFS) begin
      sel_rsvd = 1'b1;
    end else if (paddr == `EXTINT_OFS) begin
      sel_extint = 1'b1;
    end else if (paddr == `MODE_OFS) begin
      sel_mode = 1'b1;
    end else if (paddr == `STATUS_OFS) begin
      sel_status = 1'b1;
    end
  end

  assign sel_any = sel_pull || sel_drive || sel_ebus || sel_rsvd
                || sel_extint || sel_mode || sel_status;

  // ************************************
  // read mux
  // ************************************
  always_comb begin
    rd_d = 8'h00;
    if (!present) begin
      rd_d = 8'h00;
    end else if (sel_pull) begin
      rd_d = pull_q;
    end else if (sel_drive) begin
      rd_d = drive_q;
    end else if (sel_ebus) begin
      rd_d = {7'h00, stretch_q};
    end else if (sel_rsvd) begin
      rd_d = 8'h00;
    end else if (sel_extint) begin
      rd_d = {edge_sel_q, connect_q, 6'h00};
    end else if (sel_mode) begin
      rd_d = {mode_q, 5'h00};
    end else if (sel_status) begin
      rd_d = {3'h0, secure_mode, edge_used_q, stretch_used_q,
              ei.level, ei.latched};
    end
  end

  // read data is captured in setup so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
      rd_err_q   <= 1'b0;
      echo_q     <= 1'b0;
    end else if (clk_en) begin
      if (setup) begin
        rd_valid_q <= 1'b1;
        rd_data_q  <= rd_d;
        rd_err_q   <= present && !sel_any;
        echo_q     <= !present;
      end else if (psel && penable) begin
        rd_valid_q <= 1'b0;
        echo_q     <= 1'b0;
      end
    end
  end

  assign pready   = psel && penable && rd_valid_q && clk_en;
  assign pslverr  = pready && rd_err_q;
  assign prdata   = {24'h000000, rd_data_q};
  assign ext_echo = echo_q && psel;

  // ************************************
  // operating mode
  // ************************************
  // strap is caught on the first enabled edge after release
  always_comb begin
    mode_ok = 1'b0;
    if (secure_mode) begin
      mode_ok = 1'b0;
    end else if (mode_new == MODE_SPC_PERIPH) begin
      mode_ok = 1'b0;
    end else if ((mode_q == MODE_SPC_SINGLE) || (mode_q == MODE_SPC_TEST)) begin
      mode_ok = 1'b1;
    end else if (mode_q == MODE_NRM_SINGLE) begin
      mode_ok = !mode_once_used_q && mode_new[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q           <= MODE_SPC_SINGLE;
      strap_done_q     <= 1'b0;
      mode_once_used_q <= 1'b0;
    end else if (clk_en) begin
      if (!strap_done_q) begin
        mode_q       <= opmode_t'(mode_strap);
        strap_done_q <= 1'b1;
      end else if (wr_fire && sel_mode && mode_ok) begin
        mode_q <= mode_new;
        // leaving special for normal single grants one more write
        mode_once_used_q <= (mode_q == MODE_NRM_SINGLE);
      end
    end
  end

  assign opmode = mode_q;

  // ************************************
  // pull and drive registers
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_q  <= `PULL_RST;
      drive_q <= `DRIVE_RST;
    end else if (clk_en) begin
      if (wr_fire && sel_pull) begin
        pull_q <= wbyte & `PORT_MASK;
      end
      if (wr_fire && sel_drive) begin
        drive_q <= wbyte & `PORT_MASK;
      end
    end
  end

  // ************************************
  // bus control register
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_q      <= 1'b0;
      stretch_used_q <= 1'b0;
    end else if (clk_en && wr_fire && sel_ebus) begin
      if (is_special(mode_q) || !stretch_used_q) begin
        stretch_q      <= wbyte[`STRETCH_BIT];
        stretch_used_q <= !is_special(mode_q);
      end
    end
  end

  // single chip modes ignore the stretch selection
  assign eclk_stretch_en = stretch_q && !present;

  // ************************************
  // interrupt control register
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_q  <= 1'(`EXTINT_RST >> `EDGE_BIT);
      connect_q   <= 1'(`EXTINT_RST >> `CONNECT_BIT);
      edge_used_q <= 1'b0;
    end else if (clk_en && wr_fire && sel_extint) begin
      connect_q <= wbyte[`CONNECT_BIT];
      if (is_special(mode_q) || !edge_used_q) begin
        edge_sel_q  <= wbyte[`EDGE_BIT];
        edge_used_q <= !is_special(mode_q);
      end
    end
  end

  assign ei.edge_sel = edge_sel_q;
  assign ei.connect  = connect_q;
  assign ei.service  = irq_service;
  assign ext_int_req = ei.req;

  ext_int_detect u_detect (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .irq_pin_n (irq_pin_n),
    .ei        (ei)
  );

  // ************************************
  // pad controls
  // ************************************
  // pins 5 and 6 of port E pull while reset is held and until the first enabled edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reset_q <= 1'b1;
    end else if (clk_en) begin
      in_reset_q <= 1'b0;
    end
  end

  // pulls go through a flop, one cycle after a direction change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_a_q <= 8'h00;
      pull_b_q <= 8'h00;
      pull_e_q <= 8'h00;
      pull_k_q <= 8'h00;
    end else if (clk_en) begin
      pull_a_q <= pull_mask(pull_q[`PORT_A_BIT], dir_port_a);
      pull_b_q <= pull_mask(pull_q[`PORT_B_BIT], dir_port_b);
      pull_e_q <= pull_mask(pull_q[`PORT_E_BIT], dir_port_e)
                & `PORT_E_MASK;
      pull_k_q <= pull_mask(pull_q[`PORT_K_BIT], dir_port_k);
    end
  end

  assign pull_port_a = pull_a_q;
  assign pull_port_b = pull_b_q;
  assign pull_port_k = pull_k_q;
  assign pull_port_e = pull_e_q | (in_reset_q ? `PORT_E_RST_PULL : 8'h00);

  // drive choice is per port, whatever the pins are doing
  assign low_drive_a = {8{drive_q[`PORT_A_BIT]}};
  assign low_drive_b = {8{drive_q[`PORT_B_BIT]}};
  assign low_drive_e = {8{drive_q[`PORT_E_BIT]}};
  assign low_drive_k = {8{drive_q[`PORT_K_BIT]}};

endmodule

/* bench/core_port_config_regs_properties.sv */
// checker of the core port configuration registers, seen at the top ports
`include "core_port_map.svh"

module core_port_config_regs_properties
  import core_port_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        secure_mode,
  input wire logic [7:0]  dir_port_a,
  input wire logic [7:0]  dir_port_k,
  input wire logic [7:0]  pull_port_a,
  input wire logic [7:0]  pull_port_e,
  input wire logic [7:0]  pull_port_k,
  input wire logic [7:0]  low_drive_a,
  input wire logic        eclk_stretch_en,
  input wire logic        ext_echo,
  input wire logic [2:0]  opmode
);
  // ****
  // map presence and access steps
  // ****
  logic map_in;
  assign map_in = opmode == MODE_SPC_SINGLE || opmode == MODE_SPC_TEST
                  || opmode == MODE_NRM_SINGLE;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_drive_wr;
    psel && penable && pready && pwrite && paddr == `DRIVE_OFS && map_in;
  endsequence
  sequence s_mode_wr_sec;
    psel && penable && pready && pwrite && paddr == `MODE_OFS && secure_mode;
  endsequence

  a_pull_outputs_off: assert property (
    $past(presetn) && $stable(dir_port_a) && $stable(dir_port_k) |->
    (pull_port_a & dir_port_a) == 8'h00 && (pull_port_k & dir_port_k) == 8'h00)
    else $error("pull active on an output pin");
  a_pull_e_release: assert property (
    $past(presetn, 3) |-> pull_port_e[6:5] == 2'b00)
    else $error("port e pins 5 6 pulled after reset");
  a_drive_write: assert property (
    s_drive_wr |=> low_drive_a == {8{$past(pwdata[0])}})
    else $error("port a drive not from written bit");
  a_drive_uniform: assert property (
    low_drive_a == 8'h00 || low_drive_a == 8'hff)
    else $error("port a drive not uniform");
  a_rsvd_zero: assert property (
    psel && penable && pready && !pwrite && paddr == `RSVD_OFS |-> prdata == 32'h0)
    else $error("reserved slot read nonzero");
  a_upper_zero: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("unused read bits nonzero");
  a_echo_absent: assert property (
    psel && penable && !map_in |->
    ext_echo && !pslverr && (pwrite || !pready || prdata == 32'h0))
    else $error("absent map access not echoed");
  a_stretch_single: assert property (
    eclk_stretch_en |-> !map_in)
    else $error("stretch active in single chip mode");
  a_secure_lock: assert property (
    s_mode_wr_sec |=> $stable(opmode))
    else $error("mode changed while secure");
endmodule

bind core_port_config_regs core_port_config_regs_properties core_port_config_regs_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .secure_mode(secure_mode), .dir_port_a(dir_port_a), .dir_port_k(dir_port_k),
  .pull_port_a(pull_port_a), .pull_port_e(pull_port_e), .pull_port_k(pull_port_k),
  .low_drive_a(low_drive_a), .eclk_stretch_en(eclk_stretch_en), .ext_echo(ext_echo),
  .opmode(opmode));

/* bench/core_port_config_regs_test.sv */
// self-checking bench of the core port configuration registers
`include "core_port_map.svh"

module core_port_config_regs_test
  import core_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, secure_mode, irq_pin_n, irq_service;
  logic [7:0]  paddr, dir_port_a, dir_port_b, dir_port_e, dir_port_k;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, eclk_stretch_en, ext_echo, ext_int_req;
  logic [2:0]  mode_strap, opmode;
  logic [7:0]  pull_port_a, pull_port_b, pull_port_e, pull_port_k;
  logic [7:0]  low_drive_a, low_drive_b, low_drive_e, low_drive_k;
  byte_t       rdat;
  logic        rerr, recho, clk_en;
  int          mismatches, n_compared;

  core_port_config_regs core_port_config_regs_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_strap(mode_strap), .secure_mode(secure_mode),
    .dir_port_a(dir_port_a), .dir_port_b(dir_port_b), .dir_port_e(dir_port_e),
    .dir_port_k(dir_port_k), .irq_pin_n(irq_pin_n), .irq_service(irq_service),
    .pull_port_a(pull_port_a), .pull_port_b(pull_port_b), .pull_port_e(pull_port_e),
    .pull_port_k(pull_port_k), .low_drive_a(low_drive_a), .low_drive_b(low_drive_b),
    .low_drive_e(low_drive_e), .low_drive_k(low_drive_k),
    .eclk_stretch_en(eclk_stretch_en), .ext_echo(ext_echo), .ext_int_req(ext_int_req),
    .opmode(opmode));

  always #5 pclk = ~pclk;

  // ****
  // access and compare tasks
  // ****
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after an edge; returns one idle edge after the access
  task automatic apb(input logic [7:0] a, input logic w, input byte_t d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("MISMATCH pready expected 1 seen %b", pready);
    end
    rdat = prdata[7:0];
    rerr = pslverr;
    recho = ext_echo;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input byte_t d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input byte_t exp, input string what);
    apb(a, 1'b0, 8'h00);
    chk(what, exp, rdat);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic do_reset(input logic [2:0] strap);
    presetn <= 1'b0;
    mode_strap <= strap;
    waitc(20);
    chk("pull_e_rst", 8'h60, pull_port_e);
    presetn <= 1'b1;
    waitc(2);
  endtask

  // pin low two cycles, then settle past the synchroniser
  task automatic pin_edge;
    irq_pin_n <= 1'b0;
    waitc(2);
    irq_pin_n <= 1'b1;
    waitc(8);
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    waitc(5000);
    mismatches++;
    complete_run();
  end

  // ****
  // tests
  // ****
  initial begin
    {pclk, presetn, psel, penable, pwrite, secure_mode, irq_service} = 7'h0;
    {paddr, pwdata, irq_pin_n, mode_strap} = {8'h0, 32'h0, 1'b1, 3'b100};
    {dir_port_a, dir_port_b, dir_port_e, dir_port_k} = 32'h0f0081ff;
    {mismatches, n_compared} = 0;
    clk_en = 1'b1;
    do_reset(3'b100);
    rd(`PULL_OFS, `PULL_RST, "pull_rst");
    rd(`DRIVE_OFS, `DRIVE_RST, "drive_rst");
    rd(`EXTINT_OFS, `EXTINT_RST, "int_rst");
    wr(`RSVD_OFS, 8'hff);
    rd(`RSVD_OFS, 8'h00, "rsvd");
    rd(8'h1c, 8'h00, "unmapped");
    chk("unmapped_err", 8'h01, {7'h0, rerr});
    wr(`PULL_OFS, 8'hff);
    rd(`PULL_OFS, `PORT_MASK, "pull_bits");
    chk("pull_a", 8'hf0, pull_port_a);
    chk("pull_b", 8'hff, pull_port_b);
    chk("pull_e", 8'h1e, pull_port_e);
    chk("pull_k_out", 8'h00, pull_port_k);
    dir_port_k <= 8'h00;
    waitc(2);
    chk("pull_k_in", 8'hff, pull_port_k);
    wr(`PULL_OFS, 8'h10);
    waitc(1);
    chk("pull_a_off", 8'h00, pull_port_a | pull_port_b | pull_port_k);
    chk("pull_e_only", 8'h1e, pull_port_e);
    // enable low must freeze the pad flops
    clk_en <= 1'b0;
    dir_port_e <= 8'h00;
    waitc(3);
    chk("pull_e_frozen", 8'h1e, pull_port_e);
    clk_en <= 1'b1;
    waitc(2);
    chk("pull_e_run", 8'h9f, pull_port_e);
    wr(`DRIVE_OFS, 8'hff);
    rd(`DRIVE_OFS, `PORT_MASK, "drive_bits");
    chk("drive_ke", 8'hff, low_drive_k & low_drive_e & low_drive_b);
    wr(`DRIVE_OFS, 8'h01);
    chk("drive_a", 8'hff, low_drive_a);
    chk("drive_b", 8'h00, low_drive_b | low_drive_e | low_drive_k);
    $display("test registers done");
    wr(`EBUS_OFS, 8'h01);
    wr(`EBUS_OFS, 8'h00);
    rd(`EBUS_OFS, 8'h01, "stretch_once");
    chk("stretch_single", 8'h00, {7'h0, eclk_stretch_en});
    wr(`EXTINT_OFS, 8'hc0);
    wr(`EXTINT_OFS, 8'h40);
    rd(`EXTINT_OFS, 8'hc0, "edge_once");
    wr(`EXTINT_OFS, 8'h80);
    rd(`EXTINT_OFS, 8'h80, "connect_any");
    pin_edge();
    chk("req_disc", 8'h00, {7'h0, ext_int_req});
    wr(`EXTINT_OFS, 8'hc0);
    chk("req_reconnect", 8'h00, {7'h0, ext_int_req});
    pin_edge();
    chk("req_latch", 8'h01, {7'h0, ext_int_req});
    irq_service <= 1'b1;
    waitc(1);
    irq_service <= 1'b0;
    waitc(1);
    chk("req_service", 8'h00, {7'h0, ext_int_req});
    rd(`STATUS_OFS, 8'h0e, "status_used");
    $display("test interrupt done");
    secure_mode <= 1'b1;
    wr(`MODE_OFS, 8'ha0);
    waitc(1);
    chk("mode_secure", 8'h04, {5'h0, opmode});
    secure_mode <= 1'b0;
    wr(`MODE_OFS, 8'ha0);
    waitc(1);
    chk("mode_once", 8'h05, {5'h0, opmode});
    rd(`PULL_OFS, 8'h00, "absent_read");
    chk("absent_echo", 8'h01, {7'h0, recho});
    wr(`MODE_OFS, 8'h80);
    waitc(1);
    chk("mode_none", 8'h05, {5'h0, opmode});
    $display("test normal mode done");
    do_reset(3'b000);
    wr(`EBUS_OFS, 8'h01);
    wr(`EBUS_OFS, 8'h00);
    rd(`EBUS_OFS, 8'h00, "stretch_any");
    wr(`EBUS_OFS, 8'h01);
    irq_pin_n <= 1'b0;
    waitc(6);
    chk("req_level", 8'h01, {7'h0, ext_int_req});
    irq_pin_n <= 1'b1;
    waitc(6);
    chk("req_level_off", 8'h00, {7'h0, ext_int_req});
    wr(`EXTINT_OFS, 8'hc0);
    wr(`EXTINT_OFS, 8'h40);
    rd(`EXTINT_OFS, 8'h40, "edge_any");
    wr(`MODE_OFS, 8'h80);
    waitc(1);
    chk("mode_spc", 8'h04, {5'h0, opmode});
    rd(`MODE_OFS, 8'h80, "mode_read");
    wr(`MODE_OFS, 8'ha0);
    waitc(1);
    chk("mode_left", 8'h05, {5'h0, opmode});
    chk("stretch_exp", 8'h01, {7'h0, eclk_stretch_en});
    $display("test special mode done");
    complete_run();
  end
endmodule
